// ==== logic/ppm_pkg.sv ====
// package: register map, field layout and timing constants of the port
package ppm_pkg;
  // ---------------------------------------------------------------
  // register map (word offsets are byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_OFS  = 4'h0;
  localparam logic [3:0] ADDR_OFS  = 4'h4;
  localparam logic [3:0] DATA_OFS  = 4'h8;
  localparam logic [3:0] STAT_OFS  = 4'hC;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h7FFF;
  // ---------------------------------------------------------------
  // field positions of the mode register
  // ---------------------------------------------------------------
  localparam int BUSY_BIT  = 15;
  localparam int IRQM_LO   = 13;
  localparam int INCM_LO   = 11;
  localparam int WIDE_BIT  = 10;
  localparam int PERS_LO   = 8;
  localparam int SETUP_LO  = 6;
  localparam int STRB_LO   = 2;
  localparam int HOLD_LO   = 0;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] IRQ_NONE  = 2'h0;
  localparam logic [1:0] IRQ_CYCLE = 2'h1;
  localparam logic [1:0] IRQ_STALL = 2'h2;
  localparam logic [1:0] IRQ_BUF3  = 2'h3;
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_INC  = 2'h1;
  localparam logic [1:0] STEP_DEC  = 2'h2;
  localparam logic [1:0] STEP_BUF  = 2'h3;
  localparam logic [1:0] PERS_LEGACY = 2'h0;
  localparam logic [1:0] PERS_ENH    = 2'h1;
  localparam logic [1:0] PERS_MST2   = 2'h2;
  localparam logic [1:0] PERS_MST1   = 2'h3;
  localparam logic [1:0] LAST_BUF  = 2'h3;
  localparam int ADDR_W = 11;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  // ---------------------------------------------------------------
  // timing: one instruction cycle is one SYS_CLK cycle
  // ---------------------------------------------------------------
  localparam int TCY_NS = 20;
  localparam int CLK_NS = 20;
  localparam int TCY_CYC = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ONE_TCY = 4'(TCY_CYC);
  // ---------------------------------------------------------------
  // carried groups
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] irq_request_mode;
    logic [1:0] addr_step_mode;
    logic       wide_data_select;
    logic [1:0] port_personality;
    logic [1:0] setup_wait_sel;
    logic [3:0] strobe_wait_sel;
    logic [1:0] hold_wait_sel;
  } ppm_cfg_s;
  typedef struct packed {
    logic              write;
    logic [15:0]       data;
  } ppm_req_s;
  typedef struct packed {
    logic              cs;
    logic              rd;
    logic              wr;
    logic              en;
    logic              rw;
    logic              be;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        dout;
    logic              doe_n;
  } ppm_pins_s;
endpackage

// ==== logic/ppm_fifo2.sv ====
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module ppm_fifo2 (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire ppm_pkg::ppm_req_s in_data,
  input  wire logic          in_valid,
  output logic               in_ready,
  output ppm_pkg::ppm_req_s  out_data,
  output logic               out_valid,
  input  wire logic          out_ready
);
  import ppm_pkg::*;
  ppm_req_s   mem [2];
  logic       wp;
  logic       rp;
  logic [1:0] cnt;
  logic       push;
  logic       pop;
  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (push) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
    end
  end
  overflow_guard_a: assert property (@(posedge clk) disable iff (!rstn)
    cnt == 2'h2 |-> wp == rp && !push) else $error("buffer full state broken");
endmodule

// ==== logic/ppm_timer.sv ====
// wait-state down counter for setup, strobe and hold phases
`timescale 1ns/1ps
module ppm_timer (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       load,
  input  wire logic [3:0] count,
  output logic            done
);
  import ppm_pkg::*;
  logic [3:0] remain;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain <= 4'h0;
    end else if (load) begin
      remain <= 4'(count - ONE_TCY);
    end else if (remain != 4'h0) begin
      remain <= 4'(remain - ONE_TCY);
    end
  end
  // no term from load here: the engine loads on done, so that would loop
  assign done = (remain == 4'h0);
endmodule

// ==== logic/ppm_top.sv ====
// parallel port mode control with master engine and slave buffers
`timescale 1ns/1ps
module ppm_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             PORT_IRQ,
  output logic             CPU_STALL,
  output logic             CS_OUT,
  output logic             RD_OUT,
  output logic             RD_OE_N,
  output logic             WR_OUT,
  output logic             WR_OE_N,
  output logic             ENB_OUT,
  output logic             BE_OUT,
  output logic [10:0]      ADDR_OUT,
  output logic [7:0]       DATA_OUT,
  output logic             DATA_OE_N,
  input  wire logic [7:0]  DATA_IN,
  input  wire logic        RD_IN,
  input  wire logic        WR_IN,
  input  wire logic        CS_IN,
  input  wire logic [1:0]  ADDR_IN
);
  import ppm_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_STRB  = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_DONE  = 5'b10000
  } ppm_state_e;
  ppm_state_e  state;
  ppm_cfg_s    cfg;
  logic [ADDR_W-1:0] port_addr;
  logic [15:0] data_reg;
  logic        busy;
  logic        hi_phase;
  logic        second_pending;
  logic [7:0]  buf_mem [4];
  logic [1:0]  buf_ptr;
  logic        is_master;
  logic        tmr_load;
  logic [3:0]  tmr_count;
  logic        tmr_done;
  logic        bus_access;
  logic        bus_hit;
  logic        cycle_end;
  ppm_req_s    q_in;
  logic        q_in_valid;
  logic        q_in_ready;
  ppm_req_s    q_out;
  logic        q_out_valid;
  logic        q_out_ready;
  logic [2:0]  rd_sync1;
  logic [2:0]  rd_sync2;
  logic [1:0]  a_sync1;
  logic [1:0]  a_sync2;
  logic [7:0]  d_sync1;
  logic [7:0]  d_sync2;
  logic        slv_rd_q;
  logic        slv_wr_q;
  logic        slv_rd_rise;
  logic        slv_wr_rise;
  logic        slv_access;
  logic        slv_last;
  logic        cur_write;
  assign is_master = cfg.port_personality[1];
  assign bus_access = AVS_READ || AVS_WRITE;
  // ---------------------------------------------------------------
  // register bus: two wait cycles, then answer; data writes stall
  // while the buffer is full, which is the back-pressure path
  // ---------------------------------------------------------------
  assign q_in.write = AVS_WRITE;
  assign q_in.data  = AVS_WRITEDATA[15:0];
  assign q_in_valid = bus_hit && AVS_ADDRESS == DATA_OFS && is_master;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bus_hit <= 1'b0;
    end else begin
      bus_hit <= bus_access && AVS_WAITREQUEST && !bus_hit;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (!AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (bus_hit) begin
      AVS_WAITREQUEST <= !(q_in_ready || !q_in_valid);
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && bus_hit) begin
      unique case (AVS_ADDRESS)
        MODE_OFS: AVS_READDATA <= {16'h0000, busy, cfg};
        ADDR_OFS: AVS_READDATA <= {21'h0, port_addr};
        DATA_OFS: AVS_READDATA <= {16'h0000, data_reg};
        STAT_OFS: AVS_READDATA <= {30'h0, slv_last, busy};
        default:  AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // mode register
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg <= ppm_cfg_s'(MODE_RST[14:0]);
    end else if (AVS_WRITE && bus_hit && AVS_ADDRESS == MODE_OFS) begin
      cfg <= ppm_cfg_s'(AVS_WRITEDATA[14:0] & MODE_WMASK[14:0]);
    end
  end
  ppm_fifo2 u_fifo (
    .clk       (SYS_CLK),
    .rstn      (RSTN),
    .in_data   (q_in),
    .in_valid  (q_in_valid && AVS_WAITREQUEST && q_in_ready),
    .in_ready  (q_in_ready),
    .out_data  (q_out),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready)
  );
  // ---------------------------------------------------------------
  // master engine
  // ---------------------------------------------------------------
  assign q_out_ready = (state == ST_IDLE) && is_master && !second_pending;
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = ONE_TCY;
    unique case (state)
      ST_IDLE: begin
        tmr_load  = (q_out_valid && q_out_ready) || second_pending;
        tmr_count = 4'({2'h0, cfg.setup_wait_sel} + ONE_TCY);
      end
      ST_SETUP: begin
        tmr_load  = tmr_done;
        tmr_count = 4'(cfg.strobe_wait_sel + ONE_TCY);
      end
      ST_STRB: begin
        tmr_load  = tmr_done;
        tmr_count = 4'({2'h0, cfg.hold_wait_sel} + ONE_TCY);
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = ONE_TCY;
      end
    endcase
  end
  ppm_timer u_timer (
    .clk   (SYS_CLK),
    .rstn  (RSTN),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:  if (tmr_load) state <= ST_SETUP;
        ST_SETUP: if (tmr_done) state <= ST_STRB;
        ST_STRB:  if (tmr_done) state <= ST_HOLD;
        ST_HOLD:  if (tmr_done) state <= ST_DONE;
        ST_DONE:  state <= ST_IDLE;
      endcase
    end
  end
  assign cycle_end = (state == ST_DONE);
  // a wide word makes a second byte cycle without another request
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      second_pending <= 1'b0;
      hi_phase       <= 1'b0;
    end else if (state == ST_IDLE && q_out_valid && q_out_ready) begin
      second_pending <= cfg.wide_data_select;
      hi_phase       <= 1'b0;
    end else if (state == ST_IDLE && second_pending) begin
      second_pending <= 1'b0;
      hi_phase       <= 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      data_reg <= 16'h0000;
    end else if (state == ST_IDLE && q_out_valid && q_out_ready) begin
      data_reg <= q_out.data;
    end else if (state == ST_STRB && tmr_done && !cur_write) begin
      if (hi_phase) data_reg[15:8] <= d_sync2;
      else data_reg[7:0] <= d_sync2;
    end else if (slv_wr_rise) begin
      data_reg[7:0] <= d_sync2;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      busy <= 1'b0;
    end else begin
      busy <= is_master && (state != ST_IDLE || q_out_valid
              || second_pending);
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      port_addr <= '0;
    end else if (AVS_WRITE && bus_hit && AVS_ADDRESS == ADDR_OFS) begin
      port_addr <= AVS_WRITEDATA[ADDR_W-1:0];
    end else if (cycle_end || slv_access) begin
      unique case (cfg.addr_step_mode)
        STEP_INC: port_addr <= port_addr + ADDR_ONE;
        STEP_DEC: port_addr <= port_addr - ADDR_ONE;
        default:  port_addr <= port_addr;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // pins; the queued direction sits in the buffer entry
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur_write <= 1'b0;
    end else if (state == ST_IDLE && q_out_valid && q_out_ready) begin
      cur_write <= q_out.write;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CS_OUT    <= 1'b0;
      RD_OUT    <= 1'b0;
      WR_OUT    <= 1'b0;
      ENB_OUT   <= 1'b0;
      BE_OUT    <= 1'b0;
      ADDR_OUT  <= '0;
      DATA_OUT  <= 8'h00;
      DATA_OE_N <= 1'b1;
      RD_OE_N   <= 1'b1;
      WR_OE_N   <= 1'b1;
    end else begin
      CS_OUT   <= is_master && state != ST_IDLE && state != ST_DONE;
      BE_OUT   <= is_master && state != ST_IDLE && hi_phase;
      ADDR_OUT <= port_addr;
      DATA_OUT <= hi_phase ? data_reg[15:8] : data_reg[7:0];
      DATA_OE_N <= !(is_master && cur_write && state != ST_IDLE);
      RD_OE_N  <= !is_master;
      WR_OE_N  <= !is_master;
      if (cfg.port_personality == PERS_MST1) begin
        RD_OUT  <= !cur_write;
        WR_OUT  <= 1'b0;
        ENB_OUT <= (state == ST_STRB);
      end else begin
        RD_OUT  <= (state == ST_STRB) && !cur_write;
        WR_OUT  <= (state == ST_STRB) && cur_write;
        ENB_OUT <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // slave side: host pins pass two flip-flops first
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_sync1 <= 3'h0;
      rd_sync2 <= 3'h0;
      a_sync1  <= 2'h0;
      a_sync2  <= 2'h0;
      d_sync1  <= 8'h00;
      d_sync2  <= 8'h00;
      slv_rd_q <= 1'b0;
      slv_wr_q <= 1'b0;
    end else begin
      rd_sync1 <= {CS_IN, RD_IN, WR_IN};
      rd_sync2 <= rd_sync1;
      a_sync1  <= ADDR_IN;
      a_sync2  <= a_sync1;
      d_sync1  <= DATA_IN;
      d_sync2  <= d_sync1;
      slv_rd_q <= rd_sync2[2] && rd_sync2[1];
      slv_wr_q <= rd_sync2[2] && rd_sync2[0];
    end
  end
  assign slv_rd_rise = !is_master && rd_sync2[2] && rd_sync2[1] && !slv_rd_q;
  assign slv_wr_rise = !is_master && rd_sync2[2] && rd_sync2[0] && !slv_wr_q;
  assign slv_access  = slv_rd_rise || slv_wr_rise;
  assign slv_last = (cfg.port_personality == PERS_ENH) ? (a_sync2 == LAST_BUF)
                    : (buf_ptr == LAST_BUF);
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      buf_ptr <= 2'h0;
    end else if (slv_access && cfg.port_personality == PERS_LEGACY
                 && cfg.addr_step_mode == STEP_BUF) begin
      buf_ptr <= 2'(buf_ptr + 2'h1);
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 4; i++) buf_mem[i] <= 8'h00;
    end else if (slv_wr_rise) begin
      buf_mem[(cfg.port_personality == PERS_ENH) ? a_sync2 : buf_ptr]
        <= d_sync2;
    end
  end
  // ---------------------------------------------------------------
  // interrupt and stall
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PORT_IRQ <= 1'b0;
    end else begin
      unique case (cfg.irq_request_mode)
        IRQ_CYCLE: PORT_IRQ <= cycle_end || slv_access;
        IRQ_BUF3:  PORT_IRQ <= slv_access && slv_last;
        default:   PORT_IRQ <= 1'b0;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CPU_STALL <= 1'b0;
    end else begin
      CPU_STALL <= cfg.irq_request_mode == IRQ_STALL && is_master
                   && (state != ST_IDLE || q_out_valid
                   || second_pending);
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  no_irq_stall_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    cfg.irq_request_mode == IRQ_STALL && $stable(cfg) |=> !PORT_IRQ)
    else $error("interrupt raised in stall mode");
  busy_master_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state == ST_SETUP && is_master |=> busy)
    else $error("busy low during transfer");
  strobe_min_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state == ST_SETUP && tmr_done && cfg.strobe_wait_sel == 4'h0
    |=> state == ST_STRB ##1 state == ST_HOLD)
    else $error("strobe phase not one cycle");
  step_inc_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    cycle_end && cfg.addr_step_mode == STEP_INC && !bus_hit
    |=> port_addr == $past(port_addr) + ADDR_ONE)
    else $error("address not incremented");
  step_dec_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    cycle_end && cfg.addr_step_mode == STEP_DEC && !bus_hit
    |=> port_addr == $past(port_addr) - ADDR_ONE)
    else $error("address not decremented");
  cycle_irq_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    cycle_end && cfg.irq_request_mode == IRQ_CYCLE |=> PORT_IRQ)
    else $error("no interrupt at cycle end");
  wide_two_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state == ST_IDLE && q_out_valid && q_out_ready && cfg.wide_data_select
    |=> second_pending)
    else $error("wide word without second byte");
  setup_len_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state == ST_IDLE && tmr_load && cfg.setup_wait_sel == 2'h0
    |=> state == ST_SETUP ##1 state == ST_STRB)
    else $error("setup phase length wrong");
endmodule

// ==== verif/ppm_periph.sv ====
// behavioural peripheral that answers the master port strobes
`timescale 1ns/1ps
module ppm_periph (
  input  wire logic        clk,
  input  wire logic        cs,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic        en,
  input  wire logic        be,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  din,
  output logic [7:0]       dout
);
  logic [7:0]  byte_q[$];
  logic        be_q[$];
  logic [10:0] addr_q[$];
  logic [7:0]  cap_d;
  logic        cap_b;
  logic [10:0] cap_a;
  logic        via_en    = 1'b0;
  logic        seen      = 1'b0;
  int          setup_cnt = 0;
  int          setup_len = 0;
  int          strb_cnt  = 0;
  int          strb_len  = 0;
  initial dout = 8'h5A;
  // released bus toggles between 5A and A5, so a stale byte reads as good on every other cycle
  always @(posedge clk) begin
    dout <= (cs && rd) ? 8'hA5 : ~dout;
  end
  always @(posedge clk) begin
    if (!cs) begin
      setup_cnt <= 0;
      seen <= 1'b0;
    end else if (!(wr | en) && !seen) begin
      setup_cnt <= setup_cnt + 1;
    end
    if (wr | en) begin
      seen <= 1'b1;
      strb_cnt <= strb_cnt + 1;
      via_en <= en;
      cap_d <= din;
      cap_b <= be;
      cap_a <= addr;
      if (strb_cnt == 0) setup_len <= setup_cnt;
    end else if (strb_cnt != 0) begin
      strb_len <= strb_cnt;
      strb_cnt <= 0;
      byte_q.push_back(cap_d);
      be_q.push_back(cap_b);
      addr_q.push_back(cap_a);
    end
  end
endmodule

// ==== verif/ppm_top_bench.sv ====
// self-checking bench for the parallel port mode control block
`timescale 1ns/1ps
module ppm_top_bench;
  import ppm_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        rstn       = 1'b0;
  logic [3:0]  adr        = 4'h0;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wdat       = 32'h0;
  logic        cs_i       = 1'b0;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic [1:0]  adr_i      = 2'h0;
  logic        stall_seen = 1'b0;
  logic [31:0] rdat, got;
  logic        wreq, irq, stall, cs_o, rd_o, wr_o, enb_o, be_o, rd_oe_n;
  logic        wr_oe_n;
  logic [10:0] adr_o;
  logic [7:0]  dat_o, dat_i;
  int          irq_cnt    = 0;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          irq0, wcyc;
  ppm_top u_ppm_top (
    .SYS_CLK(sys_clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .PORT_IRQ(irq), .CPU_STALL(stall),
    .CS_OUT(cs_o), .RD_OUT(rd_o), .RD_OE_N(rd_oe_n), .WR_OUT(wr_o),
    .WR_OE_N(wr_oe_n), .ENB_OUT(enb_o), .BE_OUT(be_o), .ADDR_OUT(adr_o),
    .DATA_OUT(dat_o), .DATA_OE_N(), .DATA_IN(dat_i), .RD_IN(rd_i),
    .WR_IN(wr_i), .CS_IN(cs_i), .ADDR_IN(adr_i));
  ppm_periph u_ppm_periph (
    .clk(sys_clk), .cs(cs_o), .rd(rd_o), .wr(wr_o), .en(enb_o),
    .be(be_o), .addr(adr_o), .din(dat_o), .dout(dat_i));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (stall === 1'b1) stall_seen <= 1'b1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    wcyc = 0;
    do begin
      @(posedge sys_clk);
      wcyc++;
    end while (wreq !== 1'b0 && wcyc < 100);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    check(32'(wcyc < 100), 32'h1);
  endtask
  function automatic logic [31:0] mode(logic [1:0] iq, logic [1:0] st,
    logic wd, logic [1:0] ps, logic [1:0] su, logic [3:0] sb);
    ppm_cfg_s c;
    c = '{iq, st, wd, ps, su, sb, 2'h1};
    return {17'h0, c};
  endfunction
  task automatic idle();
    int k;
    k = 0;
    do begin
      bus(1'b0, STAT_OFS, 32'h0);
      k++;
    end while (got[0] !== 1'b0 && k < 200);
  endtask
  task automatic pop(input logic [7:0] d, input logic b,
                     input logic [10:0] a);
    check(32'(u_ppm_periph.byte_q.size() > 0), 32'h1);
    if (u_ppm_periph.byte_q.size() > 0) begin
      check(32'(u_ppm_periph.byte_q.pop_front()), 32'(d));
      check(32'(u_ppm_periph.be_q.pop_front()), 32'(b));
      check(32'(u_ppm_periph.addr_q.pop_front()), 32'(a));
    end
  endtask
  task automatic run(input logic [31:0] m, input logic [10:0] a,
                     input logic [31:0] d);
    bus(1'b1, MODE_OFS, m);
    bus(1'b1, ADDR_OFS, 32'(a));
    irq0 = irq_cnt;
    stall_seen = 1'b0;
    bus(1'b1, DATA_OFS, d);
    idle();
  endtask
  task automatic t_regs();
    bus(1'b0, MODE_OFS, 32'h0);
    check(got, {16'h0, MODE_RST});
    bus(1'b1, MODE_OFS, 32'hFFFF);
    bus(1'b0, MODE_OFS, 32'h0);
    check(got, 32'h7FFF);
    bus(1'b1, 4'h1, 32'h55);
    bus(1'b0, 4'h1, 32'h0);
    check(got, 32'h0);
    bus(1'b1, MODE_OFS, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_mst2();
    run(mode(IRQ_CYCLE, STEP_INC, 1'b0, PERS_MST2, 2'h3, 4'h0),
        11'h7FF, 32'h3C);
    pop(8'h3C, 1'b0, 11'h7FF);
    check(32'(u_ppm_periph.byte_q.size()), 32'h0);
    check(32'(u_ppm_periph.via_en), 32'h0);
    check(32'(rd_oe_n), 32'h0);
    check(32'(u_ppm_periph.setup_len), 32'h4);
    check(32'(u_ppm_periph.strb_len), 32'h1);
    check(32'(irq_cnt - irq0), 32'h1);
    bus(1'b0, ADDR_OFS, 32'h0);
    check(got, 32'h0);
    $display("test master two done");
  endtask
  task automatic t_mst1();
    run(mode(IRQ_STALL, STEP_DEC, 1'b0, PERS_MST1, 2'h0, 4'hF),
        11'h000, 32'hA6);
    pop(8'hA6, 1'b0, 11'h000);
    check(32'(u_ppm_periph.via_en), 32'h1);
    check(32'(u_ppm_periph.setup_len), 32'h1);
    check(32'(u_ppm_periph.strb_len), 32'h10);
    check(32'(irq_cnt - irq0), 32'h0);
    check(32'(stall_seen), 32'h1);
    bus(1'b0, ADDR_OFS, 32'h0);
    check(got, 32'h7FF);
    $display("test master one done");
  endtask
  task automatic t_wide();
    run(mode(IRQ_NONE, STEP_NONE, 1'b1, PERS_MST2, 2'h1, 4'h1),
        11'h010, 32'hBEEF);
    pop(8'hEF, 1'b0, 11'h010);
    pop(8'hBE, 1'b1, 11'h010);
    check(32'(u_ppm_periph.strb_len), 32'h2);
    check(32'(irq_cnt - irq0), 32'h0);
    $display("test wide done");
  endtask
  task automatic t_fill();
    int i, w0, mx;
    mx = 0;
    run(mode(IRQ_NONE, STEP_INC, 1'b0, PERS_MST2, 2'h3, 4'hF),
        11'h100, 32'h11);
    pop(8'h11, 1'b0, 11'h100);
    w0 = wcyc;
    // queue four words behind a slow strobe so the buffer fills
    for (i = 2; i < 6; i++) begin
      bus(1'b1, DATA_OFS, 32'(i) * 32'h11);
      if (wcyc > mx) mx = wcyc;
    end
    check(32'(mx > w0), 32'h1);
    bus(1'b0, MODE_OFS, 32'h0);
    check(32'(got[BUSY_BIT]), 32'h1);
    idle();
    bus(1'b0, MODE_OFS, 32'h0);
    check(32'(got[BUSY_BIT]), 32'h0);
    for (i = 2; i < 6; i++) begin
      pop(8'(i * 32'h11), 1'b0, 11'(i + 32'hFF));
    end
    $display("test buffer done");
  endtask
  task automatic host(input logic w, input logic [1:0] a);
    @(posedge sys_clk);
    adr_i <= a;
    cs_i <= 1'b1;
    wr_i <= w;
    rd_i <= !w;
    repeat (4) @(posedge sys_clk);
    cs_i <= 1'b0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic t_slave();
    bus(1'b1, MODE_OFS,
        mode(IRQ_BUF3, STEP_NONE, 1'b0, PERS_ENH, 2'h0, 4'h0));
    irq0 = irq_cnt;
    host(1'b1, 2'h2);
    check(32'(irq_cnt - irq0), 32'h0);
    host(1'b0, 2'h3);
    check(32'(irq_cnt - irq0), 32'h1);
    check(32'({rd_oe_n, wr_oe_n}), 32'h3);
    bus(1'b1, MODE_OFS,
        mode(IRQ_BUF3, STEP_BUF, 1'b0, PERS_LEGACY, 2'h0, 4'h0));
    irq0 = irq_cnt;
    repeat (3) host(1'b1, 2'h0);
    check(32'(irq_cnt - irq0), 32'h0);
    host(1'b0, 2'h0);
    check(32'(irq_cnt - irq0), 32'h1);
    $display("test slave done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_mst2();
    t_mst1();
    t_wide();
    t_fill();
    t_slave();
    tally_and_finish();
  end
  // a few hundred cycles are expected; this bounds a hang at 20000 cycles
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
endmodule
